// *** src/drsd_params.svh ***
// What this block does
// - Accumulator stores yield a 16-bit 1.15 value fed to write saturation.
// - Rounding mode bit 1 of core config picks conventional or convergent.
// - Without a rounding request the upper word is stored truncated.
// - Conventional: add accumulator bit 15 to bits 31:16; up when low >= 0x8000.
// - Convergent: low word exactly 0x8000 rounds up only when bit 16 is one.
// - Plain store writes truncated, rounded store writes rounded, both saturated.
// - Multiply-accumulate write-back data is always rounded.
// - Shifter does up to 16-bit right or left shift in one cycle.
// - Signed amount: positive right, negative left, zero unchanged.
// - 40-bit shifter path; 40-bit DSP result, 16-bit MCU result.
// - Shifter serves arith right, logic right, left, store and accumulator shift.
// - Core config holds multiply, round, per-accumulator, write and mode saturation.
// - Interrupt control: bit 10 A overflow, bit 9 B overflow, bit 8 catastrophic.
// - Accumulator shift beyond +/-16 always raises an arithmetic error trap.
// - On that trap the instruction completes but the accumulator is not written.
// - Divider does fractional, signed long, unsigned long, signed and unsigned word.
// - Quotient goes to working register 0, remainder to working register 1.
// - Divisor and word dividend from any register; long dividend in a pair.
// - A whole divide including repeat setup takes 19 instruction cycles.
// - Divide is interruptible; partial state goes back to registers each step.
// - Write saturation clamps above 0x007FFF to 0x7FFF, below 0xFF8000 to 0x8000.
`ifndef DRSD_PARAMS_SVH
`define DRSD_PARAMS_SVH
`define DRSD_ADR_CORE_CFG   8'h00
`define DRSD_ADR_INT_CTRL   8'h04
`define DRSD_ADR_STATUS     8'h08
`define DRSD_CFG_MULT_FRAC  0
`define DRSD_CFG_ROUND      1
`define DRSD_CFG_ACC_SATMD  4
`define DRSD_CFG_WR_SAT     5
`define DRSD_CFG_SAT_B      6
`define DRSD_CFG_SAT_A      7
`define DRSD_CFG_RESET      8'h20
`define DRSD_INT_COV        8
`define DRSD_INT_OVB        9
`define DRSD_INT_OVA        10
`define DRSD_ST_SHIFT_ERR   0
`define DRSD_SHIFT_MAX      7'sd16
`define DRSD_HALF           16'h8000
`define DRSD_SAT_HI         24'sh007FFF
`define DRSD_SAT_LO         24'shFF8000
`define DRSD_POS_MAX        16'h7FFF
`define DRSD_NEG_MAX        16'h8000
`define DRSD_DIV_SETUP      5'h11
`define DRSD_DIV_FIX        5'h00
`define DRSD_FRAC_PAD       15'h0000
`endif

// *** src/drsd_pkg.sv ***
package drsd_pkg;
  typedef enum logic [7:0] {
    OP_STORE     = 8'h01,
    OP_STORE_RND = 8'h02,
    OP_MAC_WB    = 8'h04,
    OP_ASR       = 8'h08,
    OP_LSR       = 8'h10,
    OP_SL        = 8'h20,
    OP_SHIFT_ACC = 8'h40,
    OP_DIV_STEP  = 8'h80
  } drsd_op_t;
  typedef enum logic [4:0] {
    DIV_FRAC     = 5'h01,
    DIV_S_LONG   = 5'h02,
    DIV_U_LONG   = 5'h04,
    DIV_S_WORD   = 5'h08,
    DIV_U_WORD   = 5'h10
  } drsd_div_t;
endpackage : drsd_pkg

// *** src/drsd_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "drsd_params.svh"
module drsd_top (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // Operation from decoder
  input  wire logic        op_valid_i,
  input  wire logic [7:0]  op_i,
  input  wire logic [39:0] acc_i,
  input  wire logic        acc_sel_i,
  input  wire logic [6:0]  shift_amt_i,
  input  wire logic [15:0] mem_operand_i,
  // Divide step operands
  input  wire logic [4:0]  div_kind_i,
  input  wire logic [4:0]  div_count_i,
  input  wire logic [15:0] dividend_hi_i,
  input  wire logic [15:0] dividend_lo_i,
  input  wire logic [15:0] divisor_i,
  input  wire logic [15:0] quotient_i,
  input  wire logic [15:0] remainder_i,
  // Accumulator overflow events
  input  wire logic        acc_a_ovf_i,
  input  wire logic        acc_b_ovf_i,
  input  wire logic        acc_cat_ovf_i,
  // Results
  output logic             store_valid_o,
  output logic      [15:0] store_data_o,
  output logic             mcu_valid_o,
  output logic      [15:0] mcu_result_o,
  output logic             acc_we_o,
  output logic             acc_sel_o,
  output logic      [39:0] acc_result_o,
  output logic             wreg_we_o,
  output logic      [15:0] quotient_o,
  output logic      [15:0] remainder_o,
  output logic             arith_trap_o,
  // Engine mode bits
  output logic      [7:0]  core_config_o,
  output logic      [2:0]  trap_en_o
);

  logic [7:0]  core_config_reg;
  logic [2:0]  interrupt_control_reg;
  logic        shift_err_flag;
  logic        wb_req;
  logic        next_ack;
  logic [31:0] next_rdata;
  logic        round_mode_select;
  logic        write_saturation_en;

  // Signed barrel shift; right shifts replicate bit 39
  function automatic logic [39:0] shift40(
    input logic [39:0] v,
    input logic [6:0]  amt
  );
    logic [5:0] mag;
    mag = amt[6] ? 6'(-amt) : amt[5:0];
    if (amt[6]) begin
      shift40 = v << mag;
    end else begin
      shift40 = 40'($signed(v) >>> mag);
    end
  endfunction : shift40

  // Round the upper word of a scaled accumulator
  function automatic logic [23:0] round24(
    input logic [39:0] a,
    input logic        conv,
    input logic        en
  );
    logic up;
    up = 1'b0;
    if (en) begin
      if (!conv) begin
        up = a[15];
      end else begin
        up = (a[15:0] > `DRSD_HALF) ||
             ((a[15:0] == `DRSD_HALF) && a[16]);
      end
    end
    round24 = a[39:16] + {23'h000000, up};
  endfunction : round24

  // Data space write saturation; accumulator itself untouched
  function automatic logic [15:0] sat16(
    input logic [23:0] v,
    input logic        en
  );
    if (en && ($signed(v) > `DRSD_SAT_HI)) begin
      sat16 = `DRSD_POS_MAX;
    end else if (en && ($signed(v) < `DRSD_SAT_LO)) begin
      sat16 = `DRSD_NEG_MAX;
    end else begin
      sat16 = v[15:0];
    end
  endfunction : sat16

  function automatic logic [15:0] abs16(input logic [15:0] v);
    abs16 = v[15] ? 16'(-v) : v;
  endfunction : abs16

  assign round_mode_select   = core_config_reg[`DRSD_CFG_ROUND];
  assign write_saturation_en = core_config_reg[`DRSD_CFG_WR_SAT];

  // Wishbone slave: one wait state, unmapped reads give zero
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;

  always_comb begin
    next_ack   = wb_req;
    next_rdata = 32'h00000000;
    case (wb_adr_i)
      `DRSD_ADR_CORE_CFG: next_rdata = {24'h000000, core_config_reg};
      `DRSD_ADR_INT_CTRL: next_rdata = {21'h000000, interrupt_control_reg, 8'h00};
      `DRSD_ADR_STATUS:   next_rdata = {31'h00000000, shift_err_flag};
      default:            next_rdata = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      wb_ack_o <= next_ack;
      wb_dat_o <= next_ack ? next_rdata : 32'h00000000;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_config_reg <= `DRSD_CFG_RESET;
    end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == `DRSD_ADR_CORE_CFG) begin
      core_config_reg <= wb_dat_i[7:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      interrupt_control_reg <= 3'h0;
    end else if (wb_req && wb_we_i && wb_sel_i[1] &&
                 wb_adr_i == `DRSD_ADR_INT_CTRL) begin
      interrupt_control_reg <= wb_dat_i[`DRSD_INT_OVA:`DRSD_INT_COV];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      core_config_o <= `DRSD_CFG_RESET;
      trap_en_o     <= 3'h0;
    end else begin
      core_config_o <= core_config_reg;
      trap_en_o     <= interrupt_control_reg;
    end
  end

  // Datapath decode
  logic        is_store;
  logic        is_rnd;
  logic        is_mcu;
  logic        is_acc_sh;
  logic        is_div;
  logic        range_err;
  logic [39:0] mcu_in;
  logic [6:0]  mcu_amt;
  logic [39:0] scaled;
  logic [39:0] mcu_sh;

  assign is_store  = op_valid_i && (op_i == drsd_pkg::OP_STORE ||
                     op_i == drsd_pkg::OP_STORE_RND ||
                     op_i == drsd_pkg::OP_MAC_WB);
  assign is_rnd    = op_i == drsd_pkg::OP_STORE_RND ||
                     op_i == drsd_pkg::OP_MAC_WB;
  assign is_mcu    = op_valid_i && (op_i == drsd_pkg::OP_ASR ||
                     op_i == drsd_pkg::OP_LSR ||
                     op_i == drsd_pkg::OP_SL);
  assign is_acc_sh = op_valid_i && op_i == drsd_pkg::OP_SHIFT_ACC;
  assign is_div    = op_valid_i && op_i == drsd_pkg::OP_DIV_STEP;
  assign range_err = ($signed(shift_amt_i) > `DRSD_SHIFT_MAX) ||
                     ($signed(shift_amt_i) < -`DRSD_SHIFT_MAX);

  // Memory operand sits in the low word; sign fill only for arith right
  always_comb begin
    mcu_in  = {24'h000000, mem_operand_i};
    mcu_amt = shift_amt_i;
    if (op_i == drsd_pkg::OP_ASR) begin
      mcu_in = {{24{mem_operand_i[15]}}, mem_operand_i};
    end else if (op_i == drsd_pkg::OP_SL) begin
      mcu_amt = 7'(-shift_amt_i);
    end
  end

  assign scaled = shift40(acc_i, shift_amt_i);
  assign mcu_sh = shift40(mcu_in, mcu_amt);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      store_valid_o <= 1'b0;
      store_data_o  <= 16'h0000;
    end else begin
      store_valid_o <= is_store;
      if (is_store) begin
        store_data_o <= sat16(round24(scaled, round_mode_select, is_rnd),
                              write_saturation_en);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mcu_valid_o  <= 1'b0;
      mcu_result_o <= 16'h0000;
    end else begin
      mcu_valid_o <= is_mcu;
      if (is_mcu) begin
        mcu_result_o <= mcu_sh[15:0];
      end
    end
  end

  // Out-of-range shift still retires but never reaches the accumulator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      acc_we_o     <= 1'b0;
      acc_sel_o    <= 1'b0;
      acc_result_o <= 40'h0000000000;
    end else begin
      acc_we_o <= is_acc_sh && !range_err;
      if (is_acc_sh) begin
        acc_sel_o    <= acc_sel_i;
        acc_result_o <= scaled;
      end
    end
  end

  // Shift range trap has no enable; overflow traps are gated
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arith_trap_o <= 1'b0;
    end else begin
      arith_trap_o <= (is_acc_sh && range_err) ||
        (acc_a_ovf_i && interrupt_control_reg[2]) ||
        (acc_b_ovf_i && interrupt_control_reg[1]) ||
        (acc_cat_ovf_i && interrupt_control_reg[0]);
    end
  end

  // Sticky; a new error wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      shift_err_flag <= 1'b0;
    end else if (is_acc_sh && range_err) begin
      shift_err_flag <= 1'b1;
    end else if (wb_req && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == `DRSD_ADR_STATUS &&
                 wb_dat_i[`DRSD_ST_SHIFT_ERR]) begin
      shift_err_flag <= 1'b0;
    end
  end

  // Divide: step 17 loads magnitudes, 16..1 shift-subtract, 0 fixes signs.
  // Partial values return to the working registers each step so that a
  // repeat loop can be interrupted; only the result signs stay here.
  logic        div_signed;
  logic        sign_n;
  logic        sign_d;
  logic [15:0] mag_d;
  logic [15:0] mag_hi;
  logic [15:0] mag_lo;
  logic [31:0] long_n;
  logic [31:0] mag_long;
  logic [16:0] trial;
  logic [16:0] diff;
  logic        neg_q;
  logic        neg_r;
  logic [15:0] next_q;
  logic [15:0] next_r;

  assign div_signed = div_kind_i != drsd_pkg::DIV_U_LONG &&
                      div_kind_i != drsd_pkg::DIV_U_WORD;

  always_comb begin
    long_n = {dividend_hi_i, dividend_lo_i};
    case (div_kind_i)
      drsd_pkg::DIV_FRAC:
        long_n = {{1{dividend_lo_i[15]}}, dividend_lo_i, `DRSD_FRAC_PAD};
      drsd_pkg::DIV_S_WORD:
        long_n = {{16{dividend_lo_i[15]}}, dividend_lo_i};
      drsd_pkg::DIV_U_WORD:
        long_n = {16'h0000, dividend_lo_i};
      default:
        long_n = {dividend_hi_i, dividend_lo_i};
    endcase
  end

  assign sign_n   = div_signed && long_n[31];
  assign sign_d   = div_signed && divisor_i[15];
  assign mag_long = sign_n ? 32'(-long_n) : long_n;
  assign mag_d    = sign_d ? abs16(divisor_i) : divisor_i;
  assign mag_hi   = mag_long[31:16];
  assign mag_lo   = mag_long[15:0];
  assign trial    = {remainder_i, quotient_i[15]};
  assign diff     = trial - {1'b0, mag_d};

  always_comb begin
    next_q = quotient_i;
    next_r = remainder_i;
    if (div_count_i == `DRSD_DIV_SETUP) begin
      next_q = mag_lo;
      next_r = mag_hi;
    end else if (div_count_i == `DRSD_DIV_FIX) begin
      next_q = neg_q ? 16'(-quotient_i) : quotient_i;
      next_r = neg_r ? 16'(-remainder_i) : remainder_i;
    end else if (!diff[16]) begin
      next_q = {quotient_i[14:0], 1'b1};
      next_r = diff[15:0];
    end else begin
      next_q = {quotient_i[14:0], 1'b0};
      next_r = trial[15:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      neg_q <= 1'b0;
      neg_r <= 1'b0;
    end else if (is_div && div_count_i == `DRSD_DIV_SETUP) begin
      neg_q <= sign_n ^ sign_d;
      neg_r <= sign_n;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wreg_we_o   <= 1'b0;
      quotient_o  <= 16'h0000;
      remainder_o <= 16'h0000;
    end else begin
      wreg_we_o <= is_div;
      if (is_div) begin
        quotient_o  <= next_q;
        remainder_o <= next_r;
      end
    end
  end

endmodule : drsd_top
`default_nettype wire

// *** verif/drsd_asserts.sv ***
`timescale 1ns/1ps
`default_nettype none
module drsd_asserts (
  // Clock, reset and bus
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_ack_o,
  // Operation side
  input wire logic        op_valid_i,
  input wire logic [7:0]  op_i,
  input wire logic [39:0] acc_i,
  input wire logic [6:0]  shift_amt_i,
  input wire logic        acc_a_ovf_i,
  input wire logic        acc_b_ovf_i,
  input wire logic        acc_cat_ovf_i,
  // Results
  input wire logic        store_valid_o,
  input wire logic [15:0] store_data_o,
  input wire logic        mcu_valid_o,
  input wire logic        acc_we_o,
  input wire logic [39:0] acc_result_o,
  input wire logic        wreg_we_o,
  input wire logic        arith_trap_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic sh_op;
  logic sh_bad;
  logic st_op;
  assign sh_op  = op_valid_i && op_i == drsd_pkg::OP_SHIFT_ACC;
  assign sh_bad = $signed(shift_amt_i) > 7'sh10 || $signed(shift_amt_i) < -7'sh10;
  assign st_op  = op_valid_i && op_i == drsd_pkg::OP_STORE;
  chk_ack_wait: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("bus answer late or too long");
  chk_store_pulse: assert property (st_op || op_valid_i && op_i == drsd_pkg::OP_STORE_RND
    |=> store_valid_o) else $error("store result missing");
  chk_trunc_store: assert property (st_op && shift_amt_i == 7'h00
    && acc_i[39:31] inside {9'h000, 9'h1FF} |=> store_data_o == $past(acc_i[31:16]))
    else $error("truncated store wrong");
  chk_range_trap: assert property (sh_op && sh_bad |=> arith_trap_o && !acc_we_o)
    else $error("range trap wrong");
  chk_shift_write: assert property (sh_op && !sh_bad |=> acc_we_o)
    else $error("accumulator not written");
  chk_zero_shift: assert property (sh_op && shift_amt_i == 7'h00
    |=> acc_result_o == $past(acc_i)) else $error("zero shift changed value");
  chk_div_write: assert property (op_valid_i && op_i == drsd_pkg::OP_DIV_STEP |=> wreg_we_o)
    else $error("divide step not written");
  chk_mcu_valid: assert property (op_valid_i
    && op_i inside {drsd_pkg::OP_ASR, drsd_pkg::OP_LSR, drsd_pkg::OP_SL} |=> mcu_valid_o)
    else $error("short shift result missing");
  chk_trap_cause: assert property (!sh_op && !(acc_a_ovf_i || acc_b_ovf_i || acc_cat_ovf_i)
    |=> !arith_trap_o) else $error("trap without cause");
  cover property (sh_op && sh_bad);
  cover property (wreg_we_o);
  cover property (store_valid_o);
endmodule : drsd_asserts
bind drsd_top drsd_asserts chk (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .op_valid_i,
  .op_i, .acc_i, .shift_amt_i, .acc_a_ovf_i, .acc_b_ovf_i, .acc_cat_ovf_i, .store_valid_o,
  .store_data_o, .mcu_valid_o, .acc_we_o, .acc_result_o, .wreg_we_o, .arith_trap_o);
`default_nettype wire

// *** verif/drsd_seq.sv ***
`timescale 1ns/1ps
`default_nettype none
module drsd_seq (
  // Clock and write-back from the block
  input wire logic  clk_i,
  input wire logic  wr_i,
  input wire logic  [15:0] q_i,
  input wire logic  [15:0] r_i,
  // Operation to the block
  output logic      op_valid_o,
  output logic      [7:0] op_o,
  output logic      [39:0] acc_o,
  output logic      [6:0] amt_o,
  output logic      [15:0] mem_o,
  output logic      sel_o,
  // Divide operands and working registers 0 and 1
  output logic      [4:0] kind_o,
  output logic      [4:0] cnt_o,
  output logic      [15:0] hi_o,
  output logic      [15:0] lo_o,
  output logic      [15:0] dvs_o,
  output logic      [15:0] quo_o,
  output logic      [15:0] rem_o
);
  initial {op_valid_o, op_o, acc_o, amt_o, mem_o, sel_o, kind_o, cnt_o} = '0;
  initial {hi_o, lo_o, dvs_o, quo_o, rem_o} = '0;
  task automatic issue(input logic [7:0] o, input logic [39:0] a, input logic [6:0] s,
                       input logic [15:0] m);
    @(posedge clk_i);
    {op_valid_o, op_o, acc_o, amt_o, mem_o, sel_o} <= {1'b1, o, a, s, m, a[0]};
    @(posedge clk_i);
    op_valid_o <= 1'b0;
    @(negedge clk_i);
  endtask : issue
  // Steps are two cycles apart so each write-back is fed in before the next step
  task automatic divide(input logic [4:0] k, input logic [15:0] h, l, d);
    logic [31:0] w;
    @(posedge clk_i);
    {kind_o, hi_o, lo_o, dvs_o, quo_o, rem_o} <= {k, h, l, d, 32'h00000000};
    for (int i = 17; i >= 0; i--) begin
      {op_valid_o, op_o, cnt_o} <= {1'b1, drsd_pkg::OP_DIV_STEP, 5'(i)};
      @(posedge clk_i);
      op_valid_o <= 1'b0;
      @(negedge clk_i);
      w = wr_i ? {q_i, r_i} : {quo_o, rem_o};
      @(posedge clk_i);
      {quo_o, rem_o} <= w;
    end
  endtask : divide
endmodule : drsd_seq
`default_nettype wire

// *** verif/dsp_round_shift_divide_bench.sv ***
`timescale 1ns/1ps
`default_nettype none
module dsp_round_shift_divide_bench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h00000000, wb_dat_o, rd, e;
  logic acc_a_ovf_i = 1'b0, acc_b_ovf_i = 1'b0, acc_cat_ovf_i = 1'b0;
  logic op_valid_i, acc_sel_i, wb_ack_o, store_valid_o, mcu_valid_o, acc_we_o, acc_sel_o;
  logic wreg_we_o, arith_trap_o;
  logic [7:0] op_i, core_config_o, c;
  logic [39:0] acc_i, acc_result_o, a;
  logic [6:0] shift_amt_i;
  logic [4:0] div_kind_i, div_count_i;
  logic [2:0] trap_en_o;
  logic [15:0] mem_operand_i, dividend_hi_i, dividend_lo_i, divisor_i, quotient_i, remainder_i;
  logic [15:0] store_data_o, mcu_result_o, quotient_o, remainder_o, m, d, h, l;
  integer errors = 0, checks_done = 0, seed = 32'hBD2F55F1, s, j, k, n;
  integer div_writes = 0;
  always #2.5 clk_i = ~clk_i;
  // Counts working register write-backs, one per divide step
  always @(posedge clk_i) begin
    if (wreg_we_o === 1'b1) div_writes++;
  end
  drsd_seq seq (.clk_i, .wr_i(wreg_we_o), .q_i(quotient_o), .r_i(remainder_o),
    .op_valid_o(op_valid_i), .op_o(op_i), .acc_o(acc_i), .amt_o(shift_amt_i),
    .mem_o(mem_operand_i), .sel_o(acc_sel_i), .kind_o(div_kind_i), .cnt_o(div_count_i),
    .hi_o(dividend_hi_i), .lo_o(dividend_lo_i), .dvs_o(divisor_i), .quo_o(quotient_i),
    .rem_o(remainder_i));
  drsd_top uut (.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
    .wb_dat_i, .wb_dat_o, .wb_ack_o, .op_valid_i, .op_i, .acc_i, .acc_sel_i, .shift_amt_i,
    .mem_operand_i, .div_kind_i, .div_count_i, .dividend_hi_i, .dividend_lo_i, .divisor_i,
    .quotient_i, .remainder_i, .acc_a_ovf_i, .acc_b_ovf_i, .acc_cat_ovf_i, .store_valid_o,
    .store_data_o, .mcu_valid_o, .mcu_result_o, .acc_we_o, .acc_sel_o, .acc_result_o,
    .wreg_we_o, .quotient_o, .remainder_o, .arith_trap_o, .core_config_o, .trap_en_o);
  task automatic complete_run;
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : complete_run
  task automatic chk(input string nm, input logic [39:0] ex, input logic [39:0] got);
    checks_done++;
    if (got !== ex) begin
      errors++;
      $display("wrong value %s expected %h seen %h", nm, ex, got);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] ad, input logic [31:0] dt);
    integer t;
    t = 0;
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, w, ad, 4'hF, dt};
    // Flop outputs still hold their pre-edge value here, so ack and data are sampled
    @(posedge clk_i);
    while (wb_ack_o !== 1'b1 && t < 20) begin
      @(posedge clk_i);
      t++;
    end
    if (t == 20) begin
      errors++;
      complete_run();
    end
    rd = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'b00;
  endtask : wb
  function automatic logic [15:0] exp_store(input logic rnd, cv, sat, input logic [39:0] x);
    logic [39:0] v;
    v = x;
    if (rnd && (x[15:0] > 16'h8000 || x[15:0] == 16'h8000 && (!cv || x[16])))
      v = x + 40'h0000010000;
    if (sat && $signed(v[39:16]) > 24'sh007FFF) return 16'h7FFF;
    if (sat && $signed(v[39:16]) < 24'shFF8000) return 16'h8000;
    return v[31:16];
  endfunction : exp_store
  function automatic logic [15:0] exp_mcu(input integer op, input logic [15:0] x, input integer b);
    if (op == 0) return 16'($signed(x) >>> b);
    if (op == 1) return x >> b;
    return x << b;
  endfunction : exp_mcu
  // Long division of the widened dividend truncates toward zero like the hardware
  function automatic logic [31:0] exp_div(input logic [4:0] kd, input logic [15:0] hw, lw, dw);
    longint nm;
    longint dv;
    nm = kd[2] ? longint'({hw, lw}) : kd[1] ? longint'($signed({hw, lw})) :
         kd[4] ? longint'(lw) : longint'($signed(lw));
    if (kd[0]) nm = nm <<< 15;
    dv = (kd[2] || kd[4]) ? longint'(dw) : longint'($signed(dw));
    return {16'(nm / dv), 16'(nm % dv)};
  endfunction : exp_div
  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk("config out", 40'h20, core_config_o);
    wb(1'b0, 8'h00, 32'h0);
    chk("config reg", 40'h20, rd);
    wb(1'b1, 8'h10, 32'hFFFFFFFF);
    wb(1'b0, 8'h10, 32'h0);
    chk("unmapped", 40'h0, rd);
    wb(1'b1, 8'h04, 32'h00000700);
    wb(1'b0, 8'h04, 32'h0);
    chk("trap enables", 40'h700, rd);
    chk("trap en out", 40'h7, trap_en_o);
    for (j = 0; j < 3; j++) begin
      wb(1'b1, 8'h04, 32'h00000100 << j);
      for (k = 0; k < 2; k++) begin
        @(posedge clk_i);
        {acc_a_ovf_i, acc_b_ovf_i, acc_cat_ovf_i} <= k ? ~(3'h1 << j) : 3'h1 << j;
        @(posedge clk_i);
        {acc_a_ovf_i, acc_b_ovf_i, acc_cat_ovf_i} <= 3'h0;
        @(negedge clk_i);
        chk("overflow trap", 40'(k == 0), arith_trap_o);
      end
    end
    for (s = 0; s < 4; s++) begin
      c = {2'b11, s[1], 3'b100, s[0], 1'b1};
      wb(1'b1, 8'h00, {24'h000000, c});
      @(negedge clk_i);
      chk("config out", c, core_config_o);
      for (j = 0; j < 30; j++)
        for (k = 0; k < 3; k++) begin
          a = j < 6 ? {23'h000912, j[0], 16'h7FFF + 16'(j >> 1)} : 40'({$random(seed), $random(seed)});
          seq.issue(8'h01 << k, a, 7'h00, 16'h0000);
          chk("store data", exp_store(k > 0, s[0], s[1], a), store_data_o);
        end
    end
    for (j = 0; j < 3; j++)
      for (n = 0; n < 17; n++) begin
        m = 16'($random(seed));
        seq.issue(8'h08 << j, 40'h0, 7'(n), m);
        chk("short shift", exp_mcu(j, m, n), mcu_result_o);
      end
    for (n = -17; n < 18; n++) begin
      a = 40'({$random(seed), $random(seed)});
      seq.issue(drsd_pkg::OP_SHIFT_ACC, a, 7'(n), 16'h0000);
      chk("acc write", 40'(n > -17 && n < 17), acc_we_o);
      chk("range trap", 40'(n < -16 || n > 16), arith_trap_o);
      chk("acc select", 40'(a[0]), acc_sel_o);
      if (n > -17 && n < 17) chk("acc shift", n < 0 ? a << -n : 40'($signed(a) >>> n), acc_result_o);
    end
    wb(1'b0, 8'h08, 32'h0);
    chk("shift error flag", 40'h1, rd);
    wb(1'b1, 8'h08, 32'h00000001);
    wb(1'b0, 8'h08, 32'h0);
    chk("flag cleared", 40'h0, rd);
    for (j = 0; j < 5; j++) begin
      d = 16'($random(seed)) & 16'h7FFF | 16'h0100;
      l = 16'($random(seed)) & 16'h00FF;
      l = j == 3 ? -l : l;
      h = {9'h000, d[15:9]};
      k = div_writes;
      seq.divide(5'h01 << j, h, l, d);
      @(negedge clk_i);
      chk("divide steps", 40'h12, 40'(div_writes - k));
      e = exp_div(5'h01 << j, h, l, d);
      chk("quotient", e[31:16], quotient_o);
      chk("remainder", e[15:0], remainder_o);
    end
    complete_run();
  end
endmodule : dsp_round_shift_divide_bench
`default_nettype wire
